// *** design/breaker_failure_timer_logic.sv ***
// breaker failure decision and timing logic with register port
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
// Operation
// RULE_01: sample blocking input at each cycle start
// RULE_02: pick-up unblocked asserts start, runs timers
// RULE_03: pick-up while blocked asserts blocked only
// RULE_04: late blocking clears start, releases timers
// RULE_05: blocking must lead delay expiry 5 ms
// RULE_06: one pick-up starts both timers
// RULE_07: failure delay exceeds retrip plus margins
// RULE_08: retrip enable, default on, hides output
// RULE_09: retrip after retrip delay, default 0.100s
// RULE_10: failure after failure delay, default 0.200s
// RULE_11: current-only criterion ignores trip output
// RULE_12: current-only resets when current drops
// RULE_13: current-and-trip halts until trip active
// RULE_14: current-and-trip resets when either drops
// RULE_15: current-or-trip starts on either
// RULE_16: current-or-trip fires while either holds
// RULE_17: current-or-trip resets when both drop
// RULE_18: six-state read-only condition indication
// RULE_19: five-state read-only node behaviour indication
// RULE_20: drop pick-up below 97 percent threshold
// RULE_21: any phase over common threshold picks up
// RULE_22: delays count ticks, cleared on reset
module breaker_failure_timer_logic #(
   parameter int unsigned CYCLE_CYC = bf_pkg::CYCLE_CYC_DEF,
   parameter int unsigned CUR_W = bf_pkg::CUR_W,
   parameter int unsigned DLY_W = bf_pkg::DLY_W
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic [CUR_W-1:0] cur_a_i,
   input wire logic [CUR_W-1:0] cur_b_i,
   input wire logic [CUR_W-1:0] cur_c_i,
   input wire logic [CUR_W-1:0] cur_res_i,
   input wire logic trip_mon_i,
   input wire logic breaker_failure_block_i,
   output logic start_o,
   output logic blocked_o,
   output logic retrip_o,
   output logic breaker_failure_output_o,
   output logic cycle_tick_o
);
   // ====================
   // registers
   // ====================
   logic [31:0] ctrl_q;
   logic [DLY_W-1:0] repeat_trip_delay_setting_q;
   logic [DLY_W-1:0] bf_delay_q;
   logic [CUR_W-1:0] phase_pickup_threshold_q;
   logic [CUR_W-1:0] residual_pickup_threshold_q;
   logic retrip_en;
   bf_pkg::criterion_e crit;
   bf_pkg::node_e node_mode;
   logic res_en;

   // register writes
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         ctrl_q <= bf_pkg::CTRL_RESET; // see RULE_08
         repeat_trip_delay_setting_q <= DLY_W'(bf_pkg::RETRIP_DLY_STEPS); // see RULE_09
         bf_delay_q <= DLY_W'(bf_pkg::BF_DLY_STEPS); // see RULE_10
         phase_pickup_threshold_q <= bf_pkg::PH_THR_RESET;
         residual_pickup_threshold_q <= bf_pkg::RES_THR_RESET;
      end else if (wr_i) begin
         case (addr_i)
            bf_pkg::REG_CTRL: ctrl_q <= wdata_i;
            bf_pkg::REG_RETRIP_DLY: begin
               if (retrip_en) begin
                  repeat_trip_delay_setting_q <= wdata_i[DLY_W-1:0]; // see RULE_08
               end
            end
            bf_pkg::REG_BF_DLY: bf_delay_q <= wdata_i[DLY_W-1:0];
            bf_pkg::REG_PH_THR: phase_pickup_threshold_q <= wdata_i[CUR_W-1:0];
            bf_pkg::REG_RES_THR: residual_pickup_threshold_q <= wdata_i[CUR_W-1:0];
            default: ;
         endcase
      end
   end

   assign retrip_en = ctrl_q[bf_pkg::CTRL_RETRIP_EN];
   assign crit = bf_pkg::criterion_e'(ctrl_q[bf_pkg::CTRL_MODE_LO +: 2]);
   assign node_mode = bf_pkg::node_e'(ctrl_q[bf_pkg::CTRL_NODE_LO +: 3]);
   assign res_en = ctrl_q[bf_pkg::CTRL_RES_EN];

   // ====================
   // program cycle divider
   // ====================
   logic [31:0] div_q;
   logic tick;

   // one-cycle tick every CYCLE_CYC clocks
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 32'h0000_0001;
      end
   end

   assign tick = (div_q == 32'(CYCLE_CYC - 1));
   assign cycle_tick_o = tick;

   // ====================
   // current pick-up with hysteresis
   // ====================
   logic ph_pick_q;
   logic res_pick_q;
   logic ph_over;
   logic ph_held;
   logic res_over;
   logic res_held;
   logic [CUR_W+6:0] ph_drop;
   logic [CUR_W+6:0] res_drop;
   logic [CUR_W+6:0] a_s;
   logic [CUR_W+6:0] b_s;
   logic [CUR_W+6:0] c_s;
   logic [CUR_W+6:0] r_s;
   logic cur_pick;

   // compare magnitudes scaled by 100 against 97 percent of threshold
   assign ph_drop = (CUR_W+7)'(phase_pickup_threshold_q) * (CUR_W+7)'(bf_pkg::HYST_NUM);
   assign res_drop = (CUR_W+7)'(residual_pickup_threshold_q) * (CUR_W+7)'(bf_pkg::HYST_NUM);
   assign a_s = (CUR_W+7)'(cur_a_i) * (CUR_W+7)'(bf_pkg::HYST_DEN);
   assign b_s = (CUR_W+7)'(cur_b_i) * (CUR_W+7)'(bf_pkg::HYST_DEN);
   assign c_s = (CUR_W+7)'(cur_c_i) * (CUR_W+7)'(bf_pkg::HYST_DEN);
   assign r_s = (CUR_W+7)'(cur_res_i) * (CUR_W+7)'(bf_pkg::HYST_DEN);
   assign ph_over = (cur_a_i > phase_pickup_threshold_q)
                 || (cur_b_i > phase_pickup_threshold_q)
                 || (cur_c_i > phase_pickup_threshold_q); // see RULE_21
   assign ph_held = (a_s >= ph_drop) || (b_s >= ph_drop) || (c_s >= ph_drop); // see RULE_20
   assign res_over = res_en && (cur_res_i > residual_pickup_threshold_q);
   assign res_held = res_en && (r_s >= res_drop);

   // pick-up sets on exceed, drops only below reset ratio, per program cycle
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         ph_pick_q <= 1'b0;
         res_pick_q <= 1'b0;
      end else if (tick) begin
         ph_pick_q <= ph_over || (ph_pick_q && ph_held); // see RULE_20
         res_pick_q <= res_over || (res_pick_q && res_held);
      end
   end

   assign cur_pick = ph_pick_q || res_pick_q;

   // ====================
   // criterion and blocking
   // ====================
   logic trip_q;
   logic blk_q;
   logic pickup;
   logic run;
   logic node_blk;
   logic node_off;

   // blocking and trip monitor sampled at cycle start
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         blk_q <= 1'b0;
         trip_q <= 1'b0;
      end else if (tick) begin
         blk_q <= breaker_failure_block_i; // see RULE_01
         trip_q <= trip_mon_i;
      end
   end

   assign node_blk = (node_mode == bf_pkg::NODE_BLOCKED)
                  || (node_mode == bf_pkg::NODE_TEST_BLOCKED);
   assign node_off = (node_mode == bf_pkg::NODE_OFF);

   // common starting condition per criterion
   always_comb begin
      case (crit)
         bf_pkg::CRIT_CUR_ONLY: pickup = cur_pick; // see RULE_11
         bf_pkg::CRIT_CUR_AND_TRIP: pickup = cur_pick && trip_q; // see RULE_13
         bf_pkg::CRIT_CUR_OR_TRIP: pickup = cur_pick || trip_q; // see RULE_15, RULE_17
         default: pickup = cur_pick;
      endcase
   end

   // ====================
   // sequence state machine
   // ====================
   bf_pkg::fsm_e state_q;
   bf_pkg::fsm_e state_d;
   logic eff_blk;

   assign eff_blk = blk_q || node_blk;

   // idle, timing or blocked, evaluated on the tick
   always_comb begin
      state_d = state_q;
      case (state_q)
         bf_pkg::ST_IDLE: begin
            if (pickup && !eff_blk) begin
               state_d = bf_pkg::ST_TIMING; // see RULE_02
            end else if (pickup) begin
               state_d = bf_pkg::ST_BLK; // see RULE_03
            end
         end
         bf_pkg::ST_TIMING: begin
            if (!pickup) begin
               state_d = bf_pkg::ST_IDLE; // see RULE_12
            end else if (eff_blk) begin
               state_d = bf_pkg::ST_BLK; // see RULE_04
            end
         end
         bf_pkg::ST_BLK: begin
            if (!pickup) begin
               state_d = bf_pkg::ST_IDLE;
            end else if (!eff_blk) begin
               state_d = bf_pkg::ST_TIMING;
            end
         end
         default: state_d = bf_pkg::ST_IDLE;
      endcase
   end

   // state update once per program cycle; off mode forces idle
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i || node_off) begin
         state_q <= bf_pkg::ST_IDLE;
      end else if (tick) begin
         state_q <= state_d;
      end
   end

   // timers run only in timing state, any drop clears them
   assign run = (state_q == bf_pkg::ST_TIMING); // see RULE_14
   // current-or-trip leaves timing once both have cleared

   // ====================
   // delay timers from one common pick-up
   // ====================
   logic rt_done;
   logic bf_done;
   logic [DLY_W-1:0] rt_cnt;
   logic [DLY_W-1:0] bf_cnt;

   delay_timer #(.W(DLY_W)) u_retrip_timer (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .tick_i(tick),
      .run_i(run && retrip_en), // see RULE_06
      .limit_i(repeat_trip_delay_setting_q),
      .done_o(rt_done),
      .count_o(rt_cnt)
   );

   delay_timer #(.W(DLY_W)) u_bf_timer (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .tick_i(tick),
      .run_i(run), // see RULE_06
      .limit_i(bf_delay_q),
      .done_o(bf_done),
      .count_o(bf_cnt)
   );

   // ====================
   // outputs and indications
   // ====================
   bf_pkg::condition_e cond;

   // registered function outputs
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         start_o <= 1'b0;
         blocked_o <= 1'b0;
         retrip_o <= 1'b0;
         breaker_failure_output_o <= 1'b0;
      end else begin
         start_o <= run; // see RULE_02
         blocked_o <= (state_q == bf_pkg::ST_BLK); // see RULE_03
         retrip_o <= rt_done && retrip_en; // see RULE_09
         breaker_failure_output_o <= bf_done; // see RULE_10, RULE_16
      end
   end

   // condition indication from current outputs
   always_comb begin
      if (blocked_o) begin
         cond = bf_pkg::COND_BLOCKED; // see RULE_18
      end else if (breaker_failure_output_o) begin
         cond = bf_pkg::COND_BF;
      end else if (retrip_o) begin
         cond = bf_pkg::COND_RETRIP;
      end else if (start_o) begin
         cond = bf_pkg::COND_START;
      end else if (cur_pick || trip_q) begin
         cond = bf_pkg::COND_ON;
      end else begin
         cond = bf_pkg::COND_NORMAL;
      end
   end

   // ====================
   // register read port, data one cycle after strobe
   // ====================
   logic [31:0] status;

   always_comb begin
      status = '0;
      status[bf_pkg::ST_COND_LO +: 3] = cond;
      status[bf_pkg::ST_NODE_LO +: 3] = node_mode; // see RULE_19
      status[bf_pkg::ST_START] = start_o;
      status[bf_pkg::ST_BLOCKED] = blocked_o;
      status[bf_pkg::ST_RETRIP] = retrip_o;
      status[bf_pkg::ST_BF] = breaker_failure_output_o;
      status[bf_pkg::ST_PICKUP] = cur_pick;
   end

   // read mux, unmapped reads zero
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         case (addr_i)
            bf_pkg::REG_CTRL: rdata_o <= ctrl_q;
            bf_pkg::REG_RETRIP_DLY: rdata_o <= retrip_en ? 32'(repeat_trip_delay_setting_q) : '0;
            bf_pkg::REG_BF_DLY: rdata_o <= 32'(bf_delay_q);
            bf_pkg::REG_PH_THR: rdata_o <= 32'(phase_pickup_threshold_q);
            bf_pkg::REG_RES_THR: rdata_o <= 32'(residual_pickup_threshold_q);
            bf_pkg::REG_STATUS: rdata_o <= status;
            bf_pkg::REG_RETRIP_CNT: rdata_o <= 32'(rt_cnt);
            bf_pkg::REG_BF_CNT: rdata_o <= 32'(bf_cnt);
            default: rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end
endmodule

// *** pkg/bf_pkg.sv ***
// constants, register map and enumerations for the breaker failure timer
package bf_pkg;
   // ====================
   // clock and timing
   // ====================
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned CYCLE_US = 5000;          // default program cycle, one step
   localparam int unsigned CYCLE_CYC_DEF = (CLK_HZ / 1000000) * CYCLE_US;
   localparam int unsigned RETRIP_DLY_STEPS = 20;    // 0.100 s
   localparam int unsigned BF_DLY_STEPS = 40;        // 0.200 s
   localparam int unsigned HYST_NUM = 97;            // reset ratio numerator, percent
   localparam int unsigned HYST_DEN = 100;
   localparam int unsigned DLY_W = 19;               // 1800 s / 5 ms = 360000 steps
   localparam int unsigned CUR_W = 16;

   // ====================
   // register map, word offsets
   // ====================
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_RETRIP_DLY = 4'h1;
   localparam logic [3:0] REG_BF_DLY = 4'h2;
   localparam logic [3:0] REG_PH_THR = 4'h3;
   localparam logic [3:0] REG_RES_THR = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h5;
   localparam logic [3:0] REG_RETRIP_CNT = 4'h6;
   localparam logic [3:0] REG_BF_CNT = 4'h7;

   // control field positions
   localparam int unsigned CTRL_RETRIP_EN = 0;
   localparam int unsigned CTRL_MODE_LO = 1;        // criterion, 2 bits
   localparam int unsigned CTRL_NODE_LO = 3;        // node mode, 3 bits
   localparam int unsigned CTRL_RES_EN = 6;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

   // status field positions
   localparam int unsigned ST_COND_LO = 0;          // 3 bits
   localparam int unsigned ST_NODE_LO = 3;          // 3 bits
   localparam int unsigned ST_START = 6;
   localparam int unsigned ST_BLOCKED = 7;
   localparam int unsigned ST_RETRIP = 8;
   localparam int unsigned ST_BF = 9;
   localparam int unsigned ST_PICKUP = 10;

   localparam logic [CUR_W-1:0] PH_THR_RESET = 16'h00C8;   // 0.20 In at 1000 per In
   localparam logic [CUR_W-1:0] RES_THR_RESET = 16'h04B0;  // 1.200 In at 1000 per In

   // ====================
   // enumerations
   // ====================
   typedef enum logic [1:0] {
      CRIT_CUR_ONLY = 2'b00,
      CRIT_CUR_AND_TRIP = 2'b01,
      CRIT_CUR_OR_TRIP = 2'b10
   } criterion_e;

   typedef enum logic [2:0] {
      COND_NORMAL = 3'b000,
      COND_START = 3'b001,
      COND_RETRIP = 3'b010,
      COND_BF = 3'b011,
      COND_ON = 3'b100,
      COND_BLOCKED = 3'b101
   } condition_e;

   typedef enum logic [2:0] {
      NODE_ON = 3'b000,
      NODE_BLOCKED = 3'b001,
      NODE_TEST = 3'b010,
      NODE_TEST_BLOCKED = 3'b011,
      NODE_OFF = 3'b100
   } node_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TIMING = 2'b01,
      ST_BLK = 2'b10
   } fsm_e;
endpackage

// *** design/delay_timer.sv ***
// tick counter that fires after a settable number of evaluation ticks
`timescale 1ns/1ns
module delay_timer #(
   parameter int unsigned W = 19
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic tick_i,
   input wire logic run_i,
   input wire logic [W-1:0] limit_i,
   output logic done_o,
   output logic [W-1:0] count_o
);
   logic [W-1:0] cnt_q;

   // count while running, clear whenever not running
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i || !run_i) begin
         cnt_q <= '0; // see RULE_22
      end else if (tick_i && cnt_q < limit_i) begin
         cnt_q <= cnt_q + 1'b1; // see RULE_22
      end
   end

   assign done_o = run_i && (cnt_q >= limit_i);
   assign count_o = cnt_q;
endmodule

// *** tb/bf_checker.sv ***
// port-level assertion checker for the breaker failure timer logic
`timescale 1ns/1ns
module bf_checker #(
   parameter int unsigned CYCLE_CYC = 10,
   parameter int unsigned DLY_W = 19
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic breaker_failure_block_i,
   input wire logic start_o,
   input wire logic blocked_o,
   input wire logic retrip_o,
   input wire logic breaker_failure_output_o,
   input wire logic cycle_tick_o
);
   // ====================
   // helper state
   // ====================
   logic en_q;
   logic seen_q;
   logic [DLY_W-1:0] rt_dly_q;
   logic [DLY_W-1:0] bf_dly_q;
   int unsigned gap_q;
   int unsigned run_q;
   int unsigned blk_q;
   // shadows of retrip enable and delays, as software wrote them
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         en_q <= 1'b1;
         rt_dly_q <= DLY_W'(bf_pkg::RETRIP_DLY_STEPS);
         bf_dly_q <= DLY_W'(bf_pkg::BF_DLY_STEPS);
      end else if (wr_i) begin
         if (addr_i == bf_pkg::REG_CTRL) en_q <= wdata_i[0];
         if (addr_i == bf_pkg::REG_RETRIP_DLY && en_q) rt_dly_q <= wdata_i[DLY_W-1:0];
         if (addr_i == bf_pkg::REG_BF_DLY) bf_dly_q <= wdata_i[DLY_W-1:0];
      end
   end
   // clocks since last tick, ticks under start, ticks under blocking
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         gap_q <= 0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= cycle_tick_o ? 0 : gap_q + 1;
         seen_q <= seen_q | cycle_tick_o;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i || !start_o) run_q <= 0;
      else if (cycle_tick_o) run_q <= run_q + 1;
   end
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i || !breaker_failure_block_i) blk_q <= 0;
      else if (cycle_tick_o && blk_q < 7) blk_q <= blk_q + 1;
   end
   // ====================
   // properties
   // ====================
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_rt_rise; $rose(retrip_o); endsequence
   sequence s_bf_rise; $rose(breaker_failure_output_o); endsequence
   property p_excl; !(start_o && blocked_o); endproperty
   property p_rt_start; retrip_o |-> start_o; endproperty
   property p_bf_start; breaker_failure_output_o |-> start_o; endproperty
   property p_rt_dis; !en_q |-> !retrip_o; endproperty
   property p_blk; blk_q >= 3 |-> !start_o && !retrip_o && !breaker_failure_output_o; endproperty
   property p_tick; cycle_tick_o && seen_q |-> gap_q == CYCLE_CYC - 1; endproperty
   property p_rt_delay; s_rt_rise |-> run_q == rt_dly_q; endproperty
   property p_bf_delay; s_bf_rise |-> run_q == bf_dly_q; endproperty
   property p_rd_idle; !$past(rd_i) |-> rdata_o == 32'h0000_0000; endproperty
   a_excl: assert property (p_excl) else $error("start and blocked together");
   a_rt_start: assert property (p_rt_start) else $error("retrip without start");
   a_bf_start: assert property (p_bf_start) else $error("failure without start");
   a_rt_dis: assert property (p_rt_dis) else $error("retrip while disabled");
   a_blk: assert property (p_blk) else $error("outputs kept under blocking");
   a_tick: assert property (p_tick) else $error("cycle tick period wrong");
   a_rt_delay: assert property (p_rt_delay) else $error("retrip delay wrong");
   a_bf_delay: assert property (p_bf_delay) else $error("failure delay wrong");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule

bind breaker_failure_timer_logic bf_checker #(.CYCLE_CYC(CYCLE_CYC), .DLY_W(DLY_W)) chk (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .breaker_failure_block_i(breaker_failure_block_i), .start_o(start_o),
   .blocked_o(blocked_o), .retrip_o(retrip_o),
   .breaker_failure_output_o(breaker_failure_output_o), .cycle_tick_o(cycle_tick_o)
);

// *** tb/bf_partner.sv ***
// far side model: primary protection stage, breaker and line current
`timescale 1ns/1ns
module bf_partner #(
   parameter int unsigned OPEN_CYC = 20
) (
   input wire logic ref_clk_i,
   input wire logic [15:0] lvl_i,
   input wire logic [1:0] ph_i,
   input wire logic trip_i,
   input wire logic stuck_i,
   input wire logic retrip_i,
   output logic [15:0] cur_a_o,
   output logic [15:0] cur_b_o,
   output logic [15:0] cur_c_o,
   output logic [15:0] cur_res_o,
   output logic trip_mon_o
);
   int unsigned run_q = 0;
   logic open_q = 1'b0;
   logic mon_q = 1'b0;
   logic [15:0] flow;
   // primary stage trip output follows its command one clock late
   always @(posedge ref_clk_i) begin
      mon_q <= trip_i;
   end
   // breaker opens once retrip has lasted OPEN_CYC clocks, unless stuck
   always @(posedge ref_clk_i) begin
      if (lvl_i == 16'h0000) begin
         run_q <= 0;
         open_q <= 1'b0;
      end else if (retrip_i && !stuck_i) begin
         run_q <= run_q + 1;
         open_q <= open_q || (run_q >= OPEN_CYC);
      end
   end
   // fault current on one channel, light load on the others
   assign flow = open_q ? 16'h0000 : lvl_i;
   assign cur_a_o = (ph_i == 2'h0) ? flow : 16'h0010;
   assign cur_b_o = (ph_i == 2'h1) ? flow : 16'h0010;
   assign cur_c_o = (ph_i == 2'h2) ? flow : 16'h0010;
   assign cur_res_o = (ph_i == 2'h3) ? flow : 16'h0010;
   assign trip_mon_o = mon_q;
endmodule

// *** tb/breaker_failure_timer_logic_bench.sv ***
// self-checking bench for the breaker failure timer logic
`timescale 1ns/1ns
module breaker_failure_timer_logic_bench;
   localparam int RT_D = 4;
   localparam int BF_D = 12; // above retrip, opening and release
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic blk = 1'b0;
   logic trip = 1'b0;
   logic stuck = 1'b1;
   logic [15:0] lvl = 16'h0;
   logic [1:0] ph = 2'h0;
   logic [31:0] rdata_o, d;
   logic [15:0] ca, cb, cc, cr;
   logic tm, st, bl, rt, bf, tk;
   logic [31:0] rv [9] = '{32'h1, 32'h14, 32'h28, 32'hC8, 32'h4B0, 32'h0, 32'h0, 32'h0, 32'h0};
   int hl [4] = '{1000, 1001, 970, 969};
   int mismatches = 0;
   int compares = 0;
   int cyc = 0;
   int crit, node, en, res_en, thr, rtd, bfd, el, pk, ml, mt, mb, mth, r;
   breaker_failure_timer_logic #(.CYCLE_CYC(10)) uut (
      .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cur_a_i(ca), .cur_b_i(cb),
      .cur_c_i(cc), .cur_res_i(cr), .trip_mon_i(tm), .breaker_failure_block_i(blk),
      .start_o(st), .blocked_o(bl), .retrip_o(rt), .breaker_failure_output_o(bf),
      .cycle_tick_o(tk));
   bf_partner far (.ref_clk_i(ref_clk_i), .lvl_i(lvl), .ph_i(ph), .trip_i(trip),
      .stuck_i(stuck), .retrip_i(rt), .cur_a_o(ca), .cur_b_o(cb), .cur_c_o(cc),
      .cur_res_o(cr), .trip_mon_o(tm));
   // ==================================================================
   // clock, hang limit and report
   // ==================================================================
   always #4 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_out(input logic [3:0] g, input logic [3:0] e);
      cmp_reg(32'(g), 32'(e));
   endtask
   // ==================================================================
   // register port and stimulus
   // ==================================================================
   task automatic wr(input logic [3:0] a, input int v);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= 32'(v);
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      v = rdata_o;
   endtask
   task automatic ctrl(input int c, input int n, input int e, input int re);
      crit = c;
      node = n;
      en = e;
      res_en = re;
      wr(bf_pkg::REG_CTRL, e + c * 2 + n * 8 + re * 64);
   endtask
   task automatic apply(input int l, input int p, input int t, input int b);
      @(posedge ref_clk_i);
      lvl <= 16'(l);
      ph <= 2'(p);
      trip <= t[0];
      blk <= b[0];
      ml = l;
      mt = t;
      mb = b | (node == 1) | (node == 3);
      mth = (p != 3) ? thr : (res_en ? 1200 : 65535);
   endtask
   function automatic int act();
      int a;
      a = (crit == 1) ? (pk & mt) : (crit == 2) ? (pk | mt) : pk;
      return (node == 4) ? 0 : a;
   endfunction
   // reference model advances once per program cycle tick
   task automatic step(input int n);
      repeat (n) begin
         do @(negedge ref_clk_i); while (tk !== 1'b1);
         pk = pk ? (100 * ml >= 97 * mth) : (ml > mth);
         el = (act() && !mb) ? el + 1 : 0;
      end
   endtask
   task automatic chk();
      logic s, b, t, f;
      logic [2:0] c;
      // outputs trail the model by one program cycle
      do @(negedge ref_clk_i); while (tk !== 1'b1);
      s = el >= 2;
      b = act() && mb;
      t = en && el >= rtd + 2;
      f = el >= bfd + 2;
      c = f ? 3'h3 : t ? 3'h2 : s ? 3'h1 : b ? 3'h5 : (pk | mt) ? 3'h4 : 3'h0;
      cmp_out({st, bl, rt, bf}, {s, b, t, f});
      rd(bf_pkg::REG_STATUS, d);
      cmp_reg(d & 32'h3FF, {22'h0, f, t, b, s, 3'(node), c});
   endtask
   task automatic minit();
      {crit, node, en, res_en, thr, rtd, bfd, el, pk} = {32'd0, 32'd0, 32'd1, 32'd0,
         32'd200, 32'd20, 32'd40, 32'd0, 32'd0};
   endtask
   // ==================================================================
   // tests
   // ==================================================================
   initial begin
      void'($urandom(98901));
      minit();
      repeat (3) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      foreach (rv[i]) begin
         rd(4'(i), d);
         cmp_reg(d, rv[i]);
      end
      wr(bf_pkg::REG_RETRIP_DLY, RT_D);
      wr(bf_pkg::REG_BF_DLY, BF_D);
      wr(bf_pkg::REG_PH_THR, 1000);
      {rtd, bfd, thr} = {RT_D, BF_D, 32'd1000};
      for (int k = 0; k < 16; k++) begin
         ctrl(k / 4, 0, 1, 0);
         apply(k[1] ? 1001 + $urandom % 500 : 0, $urandom % 3, k[0], 0);
         step(3);
         chk();
         step(RT_D);
         chk();
         step(BF_D - RT_D);
         chk();
         apply(ml, 0, 0, 0);
         step(3);
         chk();
         apply(0, 0, 0, 0);
         step(3);
         chk();
      end
      $display("criterion tests done");
      ctrl(0, 0, 1, 0);
      foreach (hl[i]) begin
         apply(hl[i], 1, 0, 0);
         step(3);
         chk();
      end
      for (int k = 0; k < 2; k++) begin
         ctrl(0, 0, 1, k);
         apply(1201, 3, 0, 0);
         step(3);
         chk();
         apply(0, 3, 0, 0);
         step(3);
         chk();
      end
      $display("pick-up tests done");
      ctrl(0, 0, 1, 0);
      apply(1500, 2, 0, 1);
      step(3);
      chk();
      apply(1500, 2, 0, 0);
      step(3 + RT_D);
      chk();
      apply(1500, 2, 0, 1); // well ahead of expiry
      step(3);
      chk();
      apply(0, 0, 0, 0);
      step(3);
      chk();
      for (int n = 0; n < 5; n++) begin
         ctrl(0, n, 1, 0);
         apply(1500, 0, 0, 0);
         step(3);
         chk();
         apply(0, 0, 0, 0);
         step(3);
         chk();
      end
      $display("blocking tests done");
      ctrl(0, 0, 0, 0);
      wr(bf_pkg::REG_RETRIP_DLY, 7);
      rd(bf_pkg::REG_RETRIP_DLY, d);
      cmp_reg(d, 32'h0);
      apply(1500, 1, 0, 0);
      step(BF_D + 3);
      chk();
      apply(0, 0, 0, 0);
      step(3);
      ctrl(0, 0, 1, 0);
      wr(bf_pkg::REG_RETRIP_DLY, RT_D);
      @(posedge ref_clk_i);
      stuck <= 1'b0;
      apply(1500, 0, 0, 0);
      step(3 + RT_D);
      chk();
      ml = 0;
      step(BF_D - RT_D);
      chk();
      apply(0, 0, 0, 0);
      stuck <= 1'b1;
      $display("retrip tests done");
      apply(1500, 1, 0, 0);
      step(3);
      @(posedge ref_clk_i);
      rstn_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      cmp_out({st, bl, rt, bf}, 4'h0);
      rstn_i <= 1'b1;
      minit();
      apply(1500, 1, 0, 0);
      step(3);
      chk();
      step(rtd);
      chk();
      $display("reset tests done");
      conclude();
   end
endmodule
